// ==== testbench/t1_host_model.sv ====
// host model: backplane clock, frame pulse, control streams, status capture
module t1_host_model (
  // backplane streams
  output logic bus_clock,
  output logic frame_pulse_n,
  output logic signalling_control_input_stream,
  output logic channel_option_input_stream,
  input wire logic status_output_stream
);
  timeunit 1ns;
  timeprecision 100ps;
  t1_status_pkg::word_t opt [24];
  t1_status_pkg::word_t sig [24];
  t1_status_pkg::word_t stat [32];
  t1_status_pkg::word_t shift_in;
  logic [7:0] pos;
  initial begin
    for (int c = 0; c < 24; c++) begin
      opt[c] = 8'h04;
      sig[c] = 8'h00;
    end
    {bus_clock, signalling_control_input_stream, channel_option_input_stream} = '0;
    frame_pulse_n = 1'b1;
    pos = 8'hFD;
    #7;
    forever #80 bus_clock = ~bus_clock;
  end
  // bit p is read at the rise that ends it, away from its change
  always @(posedge bus_clock) begin
    shift_in = {shift_in[6:0], status_output_stream};
    if (pos[2:0] == 3'h7) stat[pos[7:3]] = shift_in;
    pos = pos + 8'h01;
    frame_pulse_n <= (pos != 8'hFF);
    // every word sent in every frame; idle slots toggle so nothing looks held
    if (pos < 8'hC0) begin
      signalling_control_input_stream <= sig[pos[7:3]][~pos[2:0]];
      channel_option_input_stream <= opt[pos[7:3]][~pos[2:0]];
    end else begin
      signalling_control_input_stream <= ~signalling_control_input_stream;
      channel_option_input_stream <= ~channel_option_input_stream;
    end
  end
endmodule

// ==== testbench/t1_status_properties.sv ====
// port checker for the t1 status block
module t1_status_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched ports
  input wire logic bus_clock,
  input wire logic status_output_stream,
  input wire logic tx_in_valid,
  input wire logic tx_in_ready,
  input wire logic tx_out_valid,
  input wire logic tx_out_ready,
  input wire t1_status_pkg::word_t tx_out_data,
  input wire logic rx_in_valid,
  input wire logic rx_out_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_TX_TAKE: assert property (tx_in_valid && tx_in_ready |=> tx_out_valid)
    else $error("accepted word not offered");
  AST_TX_HOLD: assert property (tx_out_valid && !tx_out_ready
    |=> tx_out_valid && $stable(tx_out_data)) else $error("stalled word changed");
  AST_READY_EMPTY: assert property (!tx_out_valid |-> tx_in_ready)
    else $error("empty buffer refuses");
  AST_FULL_VALID: assert property (!tx_in_ready |-> tx_out_valid)
    else $error("refusing with nothing held");
  AST_FULL_KEEP: assert property (!tx_in_ready && !tx_out_ready |=> !tx_in_ready)
    else $error("full buffer lost a word");
  AST_RX_TAKE: assert property (rx_in_valid |=> rx_out_valid)
    else $error("receive word not delivered");
  AST_RX_PULSE: assert property (!rx_in_valid |=> !rx_out_valid)
    else $error("spurious receive word");
  // a change must come three cycles after a sample with the bus clock high
  AST_STATUS_EDGE: assert property ($changed(status_output_stream)
    |-> $past(bus_clock, 3)) else $error("status bit moved off the rising edge");
endmodule

bind t1_signalling_and_status_words t1_status_checker i_chk (.*);

// ==== testbench/tb.sv ====
// self-checking bench for the t1 signalling and status block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic bus_clock, frame_pulse_n, signalling_control_input_stream;
  logic channel_option_input_stream, status_output_stream;
  logic global_rbs_disable, esf_mode, yellow_pattern_seen, sync_entered;
  logic multiple_candidates, framing_error, extended_yellow_pattern_seen;
  logic multiframe_locked, violation, slip_done, frame_locked, rx_frame_end;
  logic rx_frame_all_ones, out_of_frame, rx_zero_seen, checksum_error;
  logic receive_8khz_marker, external_status_input, tx_in_valid, tx_in_ready;
  logic tx_sig_frame, tx_out_valid, tx_out_ready, rx_in_valid, rx_out_valid;
  t1_status_pkg::word_t tx_in_data, tx_out_data, rx_in_data, rx_out_data, loop_word;
  t1_status_pkg::slot_t tx_in_channel, rx_in_channel;
  t1_status_pkg::sig_sel_t tx_sig_sel;
  t1_status_pkg::word_t txq [$];
  t1_status_pkg::word_t rxq [$];
  logic [31:0] lfsr = 32'h84F3;
  int bad_count = 0;
  int checks = 0;

  t1_signalling_and_status_words #(.REFRESH_CYCLES(50), .BLUE_WINDOW_CYCLES(20)) i_dut (.*);
  t1_host_model i_host (.*);

  always #10 clk = ~clk;

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic [7:0] exp_tx(input logic [7:0] d, input logic [4:0] c,
      input logic sf, input logic [1:0] sel);
    logic [7:0] o;
    logic [7:0] r;
    o = i_host.opt[c];
    r = o[2] ? d : ~d;
    // outside esf the c and d selects fall back to a and b
    if (sf && !global_rbs_disable && !o[0])
      r[0] = i_host.sig[c][esf_mode ? 2'h3 - sel : {1'b1, ~sel[0]}];
    return r;
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("bad_count %0d checks %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // scoreboards sample pre-edge values, as the design does
  always @(posedge clk) begin
    if (tx_in_valid && tx_in_ready) begin
      txq.push_back(exp_tx(tx_in_data, tx_in_channel, tx_sig_frame, tx_sig_sel));
      if (tx_in_channel == 5'h05) loop_word = tx_in_data;
    end
    if (tx_out_valid && tx_out_ready) check("tx_out_data", tx_out_data, txq.pop_front());
    if (rx_in_valid) rxq.push_back(rx_in_channel == 5'h05 ? loop_word
      : (i_host.opt[rx_in_channel][2] ? rx_in_data : ~rx_in_data));
    if (rx_out_valid) check("rx_out_data", rx_out_data, rxq.pop_front());
  end

  task automatic round(input logic r1, input int nv, input int nc, input int nf,
      input logic [7:0] ep, input logic [7:0] es, input logic [7:0] pp);
    {yellow_pattern_seen, esf_mode, external_status_input} <= {3{r1}};
    {rx_frame_all_ones, out_of_frame, multiple_candidates} <= {3{r1}};
    {extended_yellow_pattern_seen, frame_locked, rx_zero_seen} <= {3{!r1}};
    {multiframe_locked, receive_8khz_marker} <= 2'h0;
    for (int i = 0; i < nv; i++) begin
      @(posedge clk);
      violation <= 1'b1;
      checksum_error <= (i < nc);
      framing_error <= (i < nf);
      slip_done <= (i == 0);
      rx_frame_end <= (i < 2);
      sync_entered <= r1 && i == 0;
      @(posedge clk);
      {violation, checksum_error, framing_error, slip_done, rx_frame_end, sync_entered} <= '0;
    end
    // rise mid-bit, clear of a position step
    @(negedge bus_clock);
    for (int i = 0; i < 300 && i_host.pos != pp; i++) @(negedge bus_clock);
    if (i_host.pos != pp) bad_count++;
    @(posedge clk);
    receive_8khz_marker <= 1'b1;
    repeat (4200) @(posedge clk);
    check("phase", i_host.stat[3], pp);
    check("primary", i_host.stat[15], ep);
    check("secondary", i_host.stat[31], es);
  endtask

  initial begin
    logic [31:0] r;
    {global_rbs_disable, esf_mode, yellow_pattern_seen, sync_entered, multiple_candidates} = '0;
    {framing_error, extended_yellow_pattern_seen, multiframe_locked, violation} = '0;
    {slip_done, frame_locked, rx_frame_end, rx_frame_all_ones, out_of_frame} = '0;
    {rx_zero_seen, checksum_error, receive_8khz_marker, external_status_input} = '0;
    {tx_in_valid, tx_sig_frame, tx_out_ready, rx_in_valid} = '0;
    {tx_in_data, tx_in_channel, rx_in_data, rx_in_channel} = '0;
    tx_sig_sel = t1_status_pkg::SIG_A;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // one looped channel only; unused bits left zero
    for (int c = 0; c < 24; c++) begin
      i_host.opt[c] = (c == 5) ? 8'h03 : 8'(rnd()) & 8'h05;
      i_host.sig[c] = 8'(rnd()) & 8'h0F;
    end
    repeat (4200) @(posedge clk);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      r = rnd();
      tx_out_ready <= r[4] & r[5];
      if (!tx_in_valid || tx_in_ready) begin
        tx_in_valid <= r[0];
        tx_in_data <= r[15:8];
        tx_in_channel <= (i < 40) ? 5'h05 : 5'(r[20:16] % 5'h18);
        tx_sig_frame <= r[1];
        tx_sig_sel <= t1_status_pkg::sig_sel_t'(r[3:2]);
        global_rbs_disable <= r[6] & r[7];
        esf_mode <= r[8];
      end
    end
    @(posedge clk);
    tx_in_valid <= 1'b0;
    tx_out_ready <= 1'b1;
    for (int i = 0; i < 20 && txq.size() > 0; i++) @(posedge clk);
    if (txq.size() > 0) bad_count++;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      r = rnd();
      rx_in_valid <= r[0];
      rx_in_data <= r[15:8];
      rx_in_channel <= r[2] ? 5'h05 : 5'(r[20:16] % 5'h18);
    end
    @(posedge clk);
    rx_in_valid <= 1'b0;
    round(1'b1, 64, 5, 0, 8'hC3, 8'hED, 8'h9A);
    round(1'b0, 192, 0, 4, 8'h7C, 8'h05, 8'h13);
    test_done();
  end
endmodule

// ==== verilog/t1_signalling_and_status_words.sv ====
// t1 per-channel control words, signalling insertion and status word streams
//
// Behaviour
// RQ1 - host sends all 24 signalling words every frame; used every sixth frame
// RQ2 - global robbed-bit disable input stops signalling insertion on all channels
// RQ3 - per-channel data enable bit stops signalling insertion on that channel
// RQ4 - polarity bit clear inverts the channel on transmit and receive
// RQ5 - loop bit replaces received channel with transmitted one; transmit unchanged
// RQ6 - host loops back at most one channel at a time
// RQ7 - host keeps internal connection bits and unused signalling bits zero
// RQ8 - A,B,C,D from bits 3..0; C and D ignored outside ESF
// RQ9 - primary bit 7 follows the all-channel bit 2 zero condition
// RQ10 - primary bit 6 set when several alignment candidates seen at sync
// RQ11 - primary bit 5 toggles per 4 framing errors, at most once per 96 ms
// RQ12 - primary bit 4 follows the ESF data link yellow pattern
// RQ13 - primary bit 3 clears once multiframe lock is reached
// RQ14 - primary bit 2 toggles every 256 bipolar violations; the code also holds it 96 ms, dropping violations while a toggle waits
// RQ15 - primary bit 1 toggles on each controlled slip
// RQ16 - primary bit 0 high while not frame synchronised
// RQ17 - secondary bit 7 blue alarm: two all-ones frames out of frame
// RQ18 - secondary bit 6 toggles when phase wraps past either end
// RQ19 - secondary bit 5 holds external status pin sampled once per frame
// RQ20 - secondary bits 4 and 3 toggle every 128 and 64 violations
// RQ21 - secondary bits 2..0 count checksum errors in ESF, wrapping
// RQ22 - phase word holds channel and bit position of marker rise
// RQ23 - all three status words sent in fixed slots every frame
`include "t1_status_defines.svh"

module t1_signalling_and_status_words #(
  parameter int REFRESH_CYCLES = `REFRESH_CYCLES,
  parameter int BLUE_WINDOW_CYCLES = `BLUE_WINDOW_CYCLES,
  parameter int CHANNELS = `DS0_CHANNELS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // backplane control streams
  input wire logic bus_clock,
  input wire logic frame_pulse_n,
  input wire logic signalling_control_input_stream,
  input wire logic channel_option_input_stream,
  output logic status_output_stream,
  // global controls
  input wire logic global_rbs_disable,
  input wire logic esf_mode,
  // receive conditions from the framer
  input wire logic yellow_pattern_seen,
  input wire logic sync_entered,
  input wire logic multiple_candidates,
  input wire logic framing_error,
  input wire logic extended_yellow_pattern_seen,
  input wire logic multiframe_locked,
  input wire logic violation,
  input wire logic slip_done,
  input wire logic frame_locked,
  input wire logic rx_frame_end,
  input wire logic rx_frame_all_ones,
  input wire logic out_of_frame,
  input wire logic rx_zero_seen,
  input wire logic checksum_error,
  // pins sampled from outside
  input wire logic receive_8khz_marker,
  input wire logic external_status_input,
  // transmit ds0 path
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  input wire t1_status_pkg::word_t tx_in_data,
  input wire t1_status_pkg::slot_t tx_in_channel,
  input wire logic tx_sig_frame,
  input wire t1_status_pkg::sig_sel_t tx_sig_sel,
  output logic tx_out_valid,
  input wire logic tx_out_ready,
  output t1_status_pkg::word_t tx_out_data,
  // receive ds0 path
  input wire logic rx_in_valid,
  input wire t1_status_pkg::word_t rx_in_data,
  input wire t1_status_pkg::slot_t rx_in_channel,
  output logic rx_out_valid,
  output t1_status_pkg::word_t rx_out_data
);
  localparam int RW = $clog2(REFRESH_CYCLES + 1);
  localparam int BW = $clog2(BLUE_WINDOW_CYCLES + 1);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic [1:0] edge_reg;
  logic bclk_s;
  logic fp_n_s;
  logic sig_s;
  logic opt_s;
  logic mark_s;
  logic xst_s;
  logic bclk_rise;
  logic bclk_fall;
  logic mark_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 6'h3F;
      sync_reg <= 6'h3F;
      edge_reg <= 2'h3;
    end else begin
      meta_reg <= {bus_clock, frame_pulse_n, signalling_control_input_stream,
                   channel_option_input_stream, receive_8khz_marker, external_status_input};
      sync_reg <= meta_reg;
      edge_reg <= {sync_reg[5], sync_reg[1]};
    end
  end

  assign {bclk_s, fp_n_s, sig_s, opt_s, mark_s, xst_s} = sync_reg;
  assign bclk_rise = bclk_s && !edge_reg[1];
  assign bclk_fall = !bclk_s && edge_reg[1];
  assign mark_rise = mark_s && !edge_reg[0];

  // ---------------------------------------------------------------
  // backplane bit position
  // ---------------------------------------------------------------
  logic [7:0] pos_reg;
  logic frame_pend_reg;
  logic [7:0] pos_next;
  logic frame_start;

  assign pos_next = frame_pend_reg ? 8'h00 : pos_reg + 8'h01;
  assign frame_start = bclk_rise && frame_pend_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg <= 8'hFF;
      frame_pend_reg <= 1'b0;
    end else begin
      if (bclk_fall && !fp_n_s) begin
        frame_pend_reg <= 1'b1;
      end else if (bclk_rise) begin
        frame_pend_reg <= 1'b0;
      end
      if (bclk_rise) begin
        pos_reg <= pos_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // control word capture, every frame
  // ---------------------------------------------------------------
  t1_status_pkg::word_t sig_mem [CHANNELS];
  t1_status_pkg::word_t opt_mem [CHANNELS];
  logic [6:0] sig_shift_reg;
  logic [6:0] opt_shift_reg;
  logic slot_ok;

  assign slot_ok = int'(pos_reg[7:3]) < CHANNELS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sig_shift_reg <= 7'h00;
      opt_shift_reg <= 7'h00;
      for (int i = 0; i < CHANNELS; i++) begin
        sig_mem[i] <= `SIG_RESET;
        opt_mem[i] <= `OPT_RESET;
      end
    end else if (bclk_fall) begin
      sig_shift_reg <= {sig_shift_reg[5:0], sig_s};
      opt_shift_reg <= {opt_shift_reg[5:0], opt_s};
      // words stored whole, so the host refreshes them every frame (see RQ1)
      if (pos_reg[2:0] == `BIT_LAST && slot_ok) begin
        sig_mem[pos_reg[7:3]] <= {sig_shift_reg, sig_s};
        opt_mem[pos_reg[7:3]] <= {opt_shift_reg, opt_s};
      end
    end
  end

  function automatic t1_status_pkg::word_t opt_of(input t1_status_pkg::slot_t ch);
    opt_of = (int'(ch) < CHANNELS) ? opt_mem[ch] : `OPT_RESET;
  endfunction

  // internal connection bits are not decoded here (see RQ7)
  function automatic t1_status_pkg::word_t invert_by(input t1_status_pkg::word_t w,
                                                     input t1_status_pkg::word_t opt);
    invert_by = opt[`OPT_POLARITY_BIT] ? w : ~w;
  endfunction

  function automatic logic sig_bit(input t1_status_pkg::word_t w,
                                   input t1_status_pkg::sig_sel_t sel, input logic esf);
    case (sel)
      t1_status_pkg::SIG_A: sig_bit = w[`SIG_A_BIT];
      t1_status_pkg::SIG_B: sig_bit = w[`SIG_B_BIT];
      t1_status_pkg::SIG_C: sig_bit = esf ? w[`SIG_C_BIT] : w[`SIG_A_BIT];
      default: sig_bit = esf ? w[`SIG_D_BIT] : w[`SIG_B_BIT];
    endcase
  endfunction

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  word_stream_if #(.WIDTH(8)) tx_fill ();
  word_stream_if #(.WIDTH(8)) tx_drain ();
  t1_status_pkg::word_t tx_opt;
  t1_status_pkg::word_t tx_word;
  t1_status_pkg::word_t loop_word_reg;
  logic rbs_on;

  // a process, so a reloaded option word is seen without a channel change
  always_comb begin
    tx_opt = opt_of(tx_in_channel);
  end
  assign rbs_on = tx_sig_frame && !global_rbs_disable // see RQ2
                  && !tx_opt[`OPT_DATA_BIT]; // see RQ3

  always_comb begin
    tx_word = invert_by(tx_in_data, tx_opt); // see RQ4
    if (rbs_on) begin
      tx_word[0] = sig_bit(sig_mem[tx_in_channel], tx_sig_sel, esf_mode); // see RQ8
    end
  end

  assign tx_fill.valid = tx_in_valid;
  assign tx_fill.data = tx_word;
  assign tx_in_ready = tx_fill.ready;
  assign tx_out_valid = tx_drain.valid;
  assign tx_out_data = tx_drain.data;
  assign tx_drain.ready = tx_out_ready;

  word_buffer #(.WIDTH(8), .DEPTH(2)) tx_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .fill(tx_fill),
    .drain(tx_drain)
  );

  // ---------------------------------------------------------------
  // receive path with loopback
  // ---------------------------------------------------------------
  t1_status_pkg::word_t rx_opt;

  always_comb begin
    rx_opt = opt_of(rx_in_channel);
  end

  // a single loop word is kept, since only one channel may loop (see RQ6)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_word_reg <= 8'h00;
    end else if (tx_in_valid && tx_in_ready && tx_opt[`OPT_LOOP_BIT]) begin
      loop_word_reg <= tx_word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_out_valid <= 1'b0;
      rx_out_data <= 8'h00;
    end else begin
      rx_out_valid <= rx_in_valid;
      if (rx_in_valid) begin
        rx_out_data <= invert_by(rx_opt[`OPT_LOOP_BIT] ? loop_word_reg : rx_in_data,
                                 rx_opt); // see RQ5
      end
    end
  end

  // ---------------------------------------------------------------
  // primary status flags
  // ---------------------------------------------------------------
  logic mimic_reg;
  logic slip_reg;
  logic [1:0] err_cnt_reg;
  logic err_pend_reg;
  logic err_toggle_reg;
  logic [RW-1:0] err_wait_reg;
  logic [7:0] bpv_cnt_reg;
  logic bpv_pend_reg;
  logic bpv_toggle_reg;
  logic [RW-1:0] bpv_wait_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mimic_reg <= 1'b0;
      slip_reg <= 1'b0;
    end else begin
      if (sync_entered) begin
        mimic_reg <= multiple_candidates; // see RQ10
      end
      if (slip_done) begin
        slip_reg <= !slip_reg; // see RQ15
      end
    end
  end

  // errors past the fourth are dropped while a toggle waits out the hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_cnt_reg <= 2'h0;
      err_pend_reg <= 1'b0;
      err_toggle_reg <= 1'b0;
      err_wait_reg <= '0;
    end else begin
      if (err_wait_reg != '0) begin
        err_wait_reg <= err_wait_reg - RW'(1);
      end
      if (err_pend_reg && err_wait_reg == '0) begin
        err_toggle_reg <= !err_toggle_reg; // see RQ11
        err_pend_reg <= 1'b0;
        err_wait_reg <= RW'(REFRESH_CYCLES - 1);
      end else if (framing_error && !err_pend_reg) begin
        err_cnt_reg <= err_cnt_reg + 2'h1;
        err_pend_reg <= (err_cnt_reg == `ERR_GROUP);
      end
    end
  end

  // the 256-violation bit keeps the same 96 ms hold as the error bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bpv_cnt_reg <= 8'h00;
      bpv_pend_reg <= 1'b0;
      bpv_toggle_reg <= 1'b0;
      bpv_wait_reg <= '0;
    end else begin
      if (bpv_wait_reg != '0) begin
        bpv_wait_reg <= bpv_wait_reg - RW'(1);
      end
      if (bpv_pend_reg && bpv_wait_reg == '0) begin
        bpv_toggle_reg <= !bpv_toggle_reg; // see RQ14
        bpv_pend_reg <= 1'b0;
        bpv_wait_reg <= RW'(REFRESH_CYCLES - 1);
      end else if (violation && !bpv_pend_reg) begin
        bpv_cnt_reg <= bpv_cnt_reg + 8'h01;
        bpv_pend_reg <= (bpv_cnt_reg == 8'hFF);
      end
    end
  end

  // ---------------------------------------------------------------
  // secondary status flags
  // ---------------------------------------------------------------
  logic [7:0] small_cnt_reg;
  logic [2:0] crc_cnt_reg;
  logic xst_reg;
  logic blue_reg;
  logic ones_seen_reg;
  logic zero_in_window_reg;
  logic [BW-1:0] window_reg;
  logic window_end;
  logic blue_set;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      small_cnt_reg <= 8'h00;
      crc_cnt_reg <= 3'h0;
      xst_reg <= 1'b0;
    end else begin
      if (violation) begin
        small_cnt_reg <= small_cnt_reg + 8'h01; // see RQ20
      end
      if (checksum_error && esf_mode) begin
        crc_cnt_reg <= crc_cnt_reg + 3'h1; // see RQ21
      end
      if (frame_start) begin
        xst_reg <= xst_s; // see RQ19
      end
    end
  end

  assign window_end = (window_reg == '0);
  assign blue_set = rx_frame_end && rx_frame_all_ones && ones_seen_reg && out_of_frame;

  // fixed 250 us windows; set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blue_reg <= 1'b0;
      ones_seen_reg <= 1'b0;
      zero_in_window_reg <= 1'b0;
      window_reg <= BW'(BLUE_WINDOW_CYCLES - 1);
    end else begin
      if (rx_frame_end) begin
        ones_seen_reg <= rx_frame_all_ones;
      end
      window_reg <= window_end ? BW'(BLUE_WINDOW_CYCLES - 1) : window_reg - BW'(1);
      if (window_end) begin
        zero_in_window_reg <= 1'b0;
      end else if (rx_zero_seen) begin
        zero_in_window_reg <= 1'b1;
      end
      if (blue_set) begin
        blue_reg <= 1'b1; // see RQ17
      end else if (window_end && (zero_in_window_reg || rx_zero_seen)) begin
        blue_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // phase measurement
  // ---------------------------------------------------------------
  logic [7:0] phase_reg;
  logic ninth_reg;

  function automatic logic wrapped(input logic [7:0] a, input logic [7:0] b);
    wrapped = (a > b) ? ((a - b) > `PHASE_WRAP) : ((b - a) > `PHASE_WRAP);
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 8'h00;
      ninth_reg <= 1'b0;
    end else if (mark_rise) begin
      phase_reg <= pos_reg; // see RQ22
      if (wrapped(pos_reg, phase_reg)) begin
        ninth_reg <= !ninth_reg; // see RQ18
      end
    end
  end

  // ---------------------------------------------------------------
  // status stream
  // ---------------------------------------------------------------
  t1_status_pkg::word_t primary_line_status;
  t1_status_pkg::word_t secondary_line_status;
  t1_status_pkg::word_t out_word_reg;
  t1_status_pkg::word_t slot_word;

  assign primary_line_status = {yellow_pattern_seen, // see RQ9
                                mimic_reg, err_toggle_reg,
                                extended_yellow_pattern_seen, // see RQ12
                                !esf_mode && !multiframe_locked, // see RQ13
                                bpv_toggle_reg, slip_reg,
                                !frame_locked}; // see RQ16
  assign secondary_line_status = {blue_reg, ninth_reg, xst_reg,
                                  small_cnt_reg[7], small_cnt_reg[6], crc_cnt_reg};

  always_comb begin
    if (pos_next[7:3] == `SLOT_PHASE) begin
      slot_word = phase_reg;
    end else if (pos_next[7:3] == `SLOT_PRIMARY) begin
      slot_word = primary_line_status;
    end else if (pos_next[7:3] == `SLOT_SECONDARY) begin
      slot_word = secondary_line_status;
    end else begin
      slot_word = 8'h00;
    end
  end

  // words latched at slot start so a bit never changes mid-slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_word_reg <= 8'h00;
    end else if (bclk_rise) begin
      if (pos_next[2:0] == 3'h0) begin
        out_word_reg <= slot_word; // see RQ23
      end else begin
        out_word_reg <= {out_word_reg[6:0], 1'b0};
      end
    end
  end

  assign status_output_stream = out_word_reg[7];
endmodule

// ==== verilog/t1_status_defines.svh ====
// constants for the t1 signalling and status word block
`ifndef T1_STATUS_DEFINES_SVH
`define T1_STATUS_DEFINES_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define CLK_HZ 50000000
`define REFRESH_MS 96
`define BLUE_WINDOW_US 250
`define REFRESH_CYCLES (`REFRESH_MS * (`CLK_HZ / 1000))
`define BLUE_WINDOW_CYCLES (`BLUE_WINDOW_US * (`CLK_HZ / 1000000))

// ---------------------------------------------------------------
// stream layout
// ---------------------------------------------------------------
`define DS0_CHANNELS 24
`define SLOT_PHASE 5'h03
`define SLOT_PRIMARY 5'h0F
`define SLOT_SECONDARY 5'h1F
`define BIT_LAST 3'h7

// ---------------------------------------------------------------
// channel option word fields, and option and signalling word reset values
// ---------------------------------------------------------------
`define OPT_DATA_BIT 0
`define OPT_LOOP_BIT 1
`define OPT_POLARITY_BIT 2
`define OPT_RESET 8'h04
`define SIG_RESET 8'h00

// ---------------------------------------------------------------
// signalling word fields
// ---------------------------------------------------------------
`define SIG_A_BIT 3
`define SIG_B_BIT 2
`define SIG_C_BIT 1
`define SIG_D_BIT 0

// ---------------------------------------------------------------
// counts
// ---------------------------------------------------------------
`define ERR_GROUP 2'h3
`define PHASE_WRAP 8'h80

`endif

// ==== verilog/t1_status_pkg.sv ====
// types shared by the t1 signalling and status word block
package t1_status_pkg;
  typedef logic [7:0] word_t;
  typedef logic [4:0] slot_t;
  typedef enum logic [1:0] {
    SIG_A = 2'h0,
    SIG_B = 2'h1,
    SIG_C = 2'h2,
    SIG_D = 2'h3
  } sig_sel_t;
endpackage

// ==== verilog/word_buffer.sv ====
// small flop fifo with valid and ready on both sides
module word_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // streams
  word_stream_if.snk fill,
  word_stream_if.src drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign fill.ready = (count_reg != CW'(DEPTH));
  assign drain.valid = (count_reg != '0);
  assign drain.data = mem_reg[rd_reg];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= fill.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= bump(wr_reg);
      end
      if (pop) begin
        rd_reg <= bump(rd_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + CW'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - CW'(1);
      end
    end
  end
endmodule

// ==== verilog/word_stream_if.sv ====
// valid/ready word stream between the block's own modules
interface word_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
